// ### common/pbr_map.svh
`ifndef PBR_MAP_SVH
`define PBR_MAP_SVH
`define PBR_ADDR_W 16
`define PBR_DATA_W 16
`define PBR_OFF_PROFILE 16'h0000
`define PBR_OFF_BLINK 16'h0001
`define PBR_OFF_VARIANT 16'h0002
`define PBR_OFF_TIMER 16'h000d
`define PBR_RST_BLINK 16'h0000
`define PBR_RST_TIMER 16'h0000
`define PBR_TIMER_MAX 16'h0005
`define PBR_VARIANT_MAX 16'h000a
`define PBR_UNMAPPED 16'h0000
`endif

// ### common/pbr_pkg.sv
package pbr_pkg;
  typedef enum logic [2:0] {
    PBR_TMR_NONE = 3'h0,
    PBR_TMR_OFF = 3'h1,
    PBR_TMR_SET = 3'h2,
    PBR_TMR_ACTIVE = 3'h3,
    PBR_TMR_RESET = 3'h4,
    PBR_TMR_MANUAL = 3'h5
  } pbr_timer_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pbr_req_s;
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] rdata;
  } pbr_rsp_s;
endpackage

// ### src/pbr_regs.sv
`timescale 1ns/1ps
`include "pbr_map.svh"
// Operation
// - Signed 16-bit values are two's complement, -32768 to 32767.
// - Unsigned 16-bit values span 0 to 65535.
// - Enumerations accept only listed codes; other writes are refused.
// - Booleans have two states, zero false and one true; the blink word keeps and reads back the raw 16-bit value written.
// - Any nonzero written boolean value is evaluated as true.
// - A 16-bit flag array holds flags 0 to 15 in one register.
// - Flag n carries weight two to the n on reads and writes.
// - A 32-bit flag array holds 32 flags with the same weighting.
// - Timer command at address 13, read-write, codes 0 to 5.
module pbr_regs (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register access from the protocol engine.
  input wire pbr_pkg::pbr_req_s req_i,
  output pbr_pkg::pbr_rsp_s rsp_o,
  // Device identity and state.
  input wire logic [15:0] profile_version_i,
  input wire logic [15:0] box_variant_i,
  // Decoded controls.
  output logic blink_active_o,
  output pbr_pkg::pbr_timer_e timer_cmd_o
);
  import pbr_pkg::*;

  // Request strobes and address hits.
  logic rd_req;
  logic wr_req;
  logic both_req;
  logic acc_req;
  logic hit_profile;
  logic hit_blink;
  logic hit_variant;
  logic hit_timer;
  logic hit_any;
  // Stored register state.
  logic [15:0] blink_raw;
  logic blink_active;
  pbr_timer_e timer_cmd;
  // Write decode.
  pbr_timer_e next_timer;
  logic timer_listed;
  logic blink_we;
  logic timer_we;
  // Identity strap path.
  logic [15:0] variant_q1;
  logic [15:0] variant_q2;
  logic [15:0] variant_q3;
  logic [15:0] variant_word;
  logic variant_listed;
  // Read data and refusal.
  logic [15:0] next_rdata;
  logic next_err;
  // Response registers.
  logic rsp_valid;
  logic rsp_err;
  logic [15:0] rsp_rdata;

  // A request with both strobes high is refused and changes nothing.
  always_comb begin
    rd_req = req_i.rd & ~req_i.wr;
    wr_req = req_i.wr & ~req_i.rd;
    both_req = req_i.rd & req_i.wr;
    acc_req = req_i.rd | req_i.wr;
  end

  // Address decode of the four words; a 32-bit flag array would take two
  // consecutive hits here, flags 0 to 15 at the lower address.
  always_comb begin
    hit_profile = 1'b0;
    hit_blink = 1'b0;
    hit_variant = 1'b0;
    hit_timer = 1'b0;
    case (req_i.addr)
      `PBR_OFF_PROFILE: begin
        hit_profile = 1'b1;
      end
      `PBR_OFF_BLINK: begin
        hit_blink = 1'b1;
      end
      `PBR_OFF_VARIANT: begin
        hit_variant = 1'b1;
      end
      `PBR_OFF_TIMER: begin
        hit_timer = 1'b1;
      end
      default: begin
        hit_profile = 1'b0;
      end
    endcase
    hit_any = hit_profile | hit_blink | hit_variant | hit_timer;
  end

  // Only listed timer codes map to a command; any other word is refused.
  always_comb begin
    next_timer = timer_cmd;
    timer_listed = 1'b1;
    case (req_i.wdata)
      16'h0000: begin
        next_timer = PBR_TMR_NONE;
      end
      16'h0001: begin
        next_timer = PBR_TMR_OFF;
      end
      16'h0002: begin
        next_timer = PBR_TMR_SET;
      end
      16'h0003: begin
        next_timer = PBR_TMR_ACTIVE;
      end
      16'h0004: begin
        next_timer = PBR_TMR_RESET;
      end
      16'h0005: begin
        next_timer = PBR_TMR_MANUAL;
      end
      default: begin
        next_timer = timer_cmd;
        timer_listed = 1'b0;
      end
    endcase
  end

  // Write enables for the two writable words.
  always_comb begin
    blink_we = wr_req & hit_blink;
    timer_we = wr_req & hit_timer & timer_listed;
  end

  // The raw boolean word is kept as written and read back unchanged.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blink_raw <= `PBR_RST_BLINK;
    end else if (blink_we) begin
      blink_raw <= req_i.wdata;
    end
  end

  // Any nonzero word counts as true; only zero counts as false.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blink_active <= 1'b0;
    end else if (blink_we) begin
      blink_active <= (req_i.wdata != 16'h0000);
    end
  end

  assign blink_active_o = blink_active;

  // The timer command keeps its value when an unlisted code is written.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_cmd <= PBR_TMR_NONE;
    end else if (timer_we) begin
      timer_cmd <= next_timer;
    end
  end

  assign timer_cmd_o = timer_cmd;

  // Two flip-flops bring the identity strap into the clock domain.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      variant_q1 <= 16'h0000;
      variant_q2 <= 16'h0000;
    end else begin
      variant_q1 <= box_variant_i;
      variant_q2 <= variant_q1;
    end
  end

  // A third stage holds the previous synchronised sample.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      variant_q3 <= 16'h0000;
    end else begin
      variant_q3 <= variant_q2;
    end
  end

  // The word is taken only when two samples agree, so skew between its
  // bits never shows up as a passing code.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      variant_word <= 16'h0000;
    end else if (variant_q2 == variant_q3) begin
      variant_word <= variant_q3;
    end
  end

  // Only listed box codes are reported.
  always_comb begin
    variant_listed = (variant_word <= `PBR_VARIANT_MAX);
  end

  // Read data for the addressed word.
  always_comb begin
    next_rdata = `PBR_UNMAPPED;
    if (hit_profile) begin
      next_rdata = profile_version_i;
    end else if (hit_blink) begin
      next_rdata = blink_raw;
    end else if (hit_variant) begin
      if (variant_listed) begin
        next_rdata = variant_word;
      end else begin
        next_rdata = 16'h0000;
      end
    end else if (hit_timer) begin
      next_rdata = {13'h0000, timer_cmd};
    end
  end

  // Writes to read-only words, unlisted codes and unmapped addresses are
  // refused.
  always_comb begin
    next_err = ~hit_any;
    if (both_req) begin
      next_err = 1'b1;
    end else if (hit_profile | hit_variant) begin
      next_err = wr_req;
    end else if (hit_timer) begin
      next_err = wr_req & ~timer_listed;
    end
  end

  // Each access is answered exactly one cycle after it is taken.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= acc_req;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_err <= 1'b0;
    end else begin
      rsp_err <= acc_req & next_err;
    end
  end

  // Words pass as raw 16-bit patterns; signedness is the master's view.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_rdata <= 16'h0000;
    end else if (rd_req) begin
      rsp_rdata <= next_rdata;
    end else begin
      rsp_rdata <= 16'h0000;
    end
  end

  always_comb begin
    rsp_o.valid = rsp_valid;
    rsp_o.err = rsp_err;
    rsp_o.rdata = rsp_rdata;
  end
endmodule

// ### tb/pbr_chk_assertions.sv
`timescale 1ns/1ps
module pbr_chk(input wire logic clk_i,input wire logic sys_rst_i,
input wire pbr_pkg::pbr_req_s req_i,input wire pbr_pkg::pbr_rsp_s rsp_o,
input wire logic blink_active_o,input wire pbr_pkg::pbr_timer_e timer_cmd_o);
default clocking @(posedge clk_i); endclocking
default disable iff (sys_rst_i);
a_rsp_next_cycle: assert property ((req_i.wr||req_i.rd)|=>rsp_o.valid)
else $error("late answer");
a_timer_code_range: assert property (timer_cmd_o<=3'h5)
else $error("bad timer");
a_timer_write_takes: assert property (req_i.wr&&!req_i.rd&&
req_i.addr==16'h000d&&
req_i.wdata<=16'h0005|=>{13'h0,timer_cmd_o}==$past(req_i.wdata))
else $error("timer not stored");
a_timer_refuse_big: assert property (req_i.wr&&req_i.addr==16'h000d&&
req_i.wdata>16'h0005|=>rsp_o.err&&$stable(timer_cmd_o))
else $error("bad code taken");
a_blink_nonzero: assert property (req_i.wr&&!req_i.rd&&
req_i.addr==16'h0001|=>
blink_active_o==($past(req_i.wdata)!=16'h0000))
else $error("blink wrong");
a_blink_holds: assert property (!(req_i.wr&&!req_i.rd&&
req_i.addr==16'h0001)|=>$stable(blink_active_o))
else $error("blink changed without write");
a_no_idle_valid: assert property (!(req_i.wr||req_i.rd)|=>
!rsp_o.valid)
else $error("answer without request");
c_err: cover property (rsp_o.valid&&rsp_o.err);
c_blink: cover property (blink_active_o);
c_manual: cover property (timer_cmd_o==pbr_pkg::PBR_TMR_MANUAL);
endmodule
bind pbr_regs pbr_chk u_pbr_chk(.clk_i(clk_i),.sys_rst_i(sys_rst_i),
.req_i(req_i),.rsp_o(rsp_o),.blink_active_o(blink_active_o),
.timer_cmd_o(timer_cmd_o));

// ### tb/pbr_master.sv
`timescale 1ns/1ps
module pbr_master(input wire logic clk_i,output pbr_pkg::pbr_req_s req_o);
initial req_o='0;
task automatic xfer(input logic w,input logic [15:0] a,input logic [15:0] d);
@(posedge clk_i);
req_o<='{w,!w,a,d};
@(posedge clk_i);
req_o<='0;
endtask
endmodule

// ### tb/test_pump_box_fieldbus_registers.sv
`timescale 1ns/1ps
`define CHK(n,e,s) begin checked++; if((s)!==(e)) begin error_cnt++; \
$display("[FAIL] %s exp %h got %h",n,e,s); end end
module test_pump_box_fieldbus_registers;
import pbr_pkg::*;
logic clk_i=0,sys_rst_i=1,bl;
logic [15:0] pv=16'h1f40,bv=16'h0003;
pbr_req_s req;
pbr_rsp_s rsp;
pbr_timer_e tc;
int error_cnt=0,checked=0;
initial forever #2.5 clk_i=~clk_i;
pbr_master u_pbr_master(.clk_i(clk_i),.req_o(req));
pbr_regs u_pbr_regs(.clk_i(clk_i),.sys_rst_i(sys_rst_i),.req_i(req),
.rsp_o(rsp),.profile_version_i(pv),.box_variant_i(bv),
.blink_active_o(bl),.timer_cmd_o(tc));
task automatic acc(input logic w,input logic [15:0] a,d,e,input logic er);
u_pbr_master.xfer(w,a,d);
#1;
`CHK("valid",1'b1,rsp.valid)
`CHK("err",er,rsp.err)
`CHK("rdata",e,rsp.rdata)
endtask
task automatic t_timer;
for (int i=0;i<6;i++) begin
acc(1,16'h000d,16'(i),16'h0,0);
`CHK("tc",3'(i),tc)
acc(0,16'h000d,16'h0,16'(i),0);
end
acc(1,16'h000d,16'h0006,16'h0,1);
`CHK("tc",PBR_TMR_MANUAL,tc)
acc(1,16'h000d,16'h0009,16'h0,1);
`CHK("tc",PBR_TMR_MANUAL,tc)
acc(0,16'h000d,16'h0,16'h0005,0);
endtask
task automatic t_blink;
acc(1,16'h0001,16'h8148,16'h0,0);
`CHK("bl",1'b1,bl)
acc(0,16'h0001,16'h0,16'h8148,0);
acc(1,16'h0001,16'h0000,16'h0,0);
`CHK("bl",1'b0,bl)
acc(1,16'h0001,16'h0001,16'h0,0);
`CHK("bl",1'b1,bl)
endtask
task automatic t_ro;
acc(0,16'h0000,16'h0,pv,0);
acc(0,16'h0002,16'h0,bv,0);
acc(1,16'h0000,16'h1234,16'h0,1);
acc(0,16'h0003,16'h0,16'h0,1);
acc(1,16'h0002,16'h0007,16'h0,1);
@(posedge clk_i);
bv<=16'h000b;
repeat(6) @(posedge clk_i);
acc(0,16'h0002,16'h0,16'h0,0);
@(posedge clk_i);
bv<=16'h000a;
repeat(6) @(posedge clk_i);
acc(0,16'h0002,16'h0,16'h000a,0);
endtask
task automatic t_reset;
acc(1,16'h000d,16'h0003,16'h0,0);
@(posedge clk_i);
sys_rst_i<=1;
repeat(2) @(posedge clk_i);
#1;
`CHK("tc",PBR_TMR_NONE,tc)
`CHK("bl",1'b0,bl)
`CHK("valid",1'b0,rsp.valid)
@(posedge clk_i);
sys_rst_i<=0;
acc(0,16'h000d,16'h0,16'h0,0);
acc(0,16'h0001,16'h0,16'h0,0);
endtask
task final_report;
$display("errors %0d checks %0d",error_cnt,checked);
if (error_cnt==0&&checked>0) $display("Simulation passed");
else $display("Simulation failed");
$finish;
endtask
initial begin
#100000;
error_cnt++;
final_report;
end
initial begin
repeat(5) @(posedge clk_i);
sys_rst_i<=0;
t_timer;
t_blink;
t_ro;
t_reset;
final_report;
end
endmodule
